// ==== tpr_pkg.sv ====
// Shared constants and types for the two-rank pipeline byte store.
package tpr_pkg;
  localparam int BYTE_W = 8;
  localparam int SYNC_DEPTH = 2;
  localparam int CTRL_W = 9;
  localparam logic [BYTE_W-1:0] RANK_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  // Bit positions inside the synchronised control word.
  localparam int C_CLK = 0;
  localparam int C_EN1_N = 1;
  localparam int C_EN2_N = 2;
  localparam int C_GATE = 3;
  localparam int C_G1_N = 4;
  localparam int C_G2_N = 5;
  localparam int C_SRC = 6;
  localparam int C_OSEL = 7;
  localparam int C_OE_N = 8;
  typedef logic [BYTE_W-1:0] tpr_byte_t;
  typedef enum logic {TPR_REGISTER, TPR_LATCH} tpr_variant_t;
endpackage

// ==== tpr_rank_if.sv ====
// Interface between the control logic and one storage rank.
`timescale 1ns/1ps
interface tpr_rank_if;
  import tpr_pkg::*;
  logic load;
  tpr_byte_t din;
  tpr_byte_t q;
  modport ctrl (output load, output din, input q);
  modport store (input load, input din, output q);
endinterface

// ==== tpr_sync.sv ====
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module tpr_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import tpr_pkg::*;
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // The first stage feeds only the second stage, never any logic.
  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Reset loads constants only; the pins are caught after release.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// ==== tpr_rank.sv ====
// One 8-bit storage rank that loads on request and otherwise holds.
`timescale 1ns/1ps
module tpr_rank (
  input wire logic core_clk,
  input wire logic rst,
  tpr_rank_if.store port
);
  import tpr_pkg::*;
  tpr_byte_t q_reg;
  tpr_byte_t q_next;

  // Without a load request the stored byte stays as it was.
  always_comb
  begin
    q_next = q_reg;
    if (port.load)
    begin
      q_next = port.din; // RL4
    end
  end

  // Storage clears at reset so the ranks never read as unknown.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      q_reg <= RANK_RST;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign port.q = q_reg;
endmodule

// ==== tpr_store.sv ====
// Top of the two-rank pipeline byte store: pin sampling, rank control, output mux.
// Function
// RL1: Two independent 8-bit ranks share one input byte and one output bus.
// RL2: In the register variant rank 1 takes the input byte on a rising shared clock edge if its enable was low before it.
// RL3: In the register variant rank 2 loads its selected source on a rising edge if its enable was low before it.
// RL4: A rank whose enable or gate is inactive, or that sees no clock edge, keeps its byte.
// RL5: The source select low makes rank 2 load rank 1, high makes it load the input byte.
// RL6: Cascaded, one enabled edge moves the input byte into rank 1 and rank 1's old byte into rank 2.
// RL7: The output select low puts rank 2 on the bus and high puts rank 1 there.
// RL8: The output enable high floats all eight bus lines and low drives the chosen byte.
// RL9: In the latch variant a rank is transparent while the common gate is high, or it is low and the rank gate is low.
// RL10: In the latch variant a rank freezes while the common gate is low and its own gate is high.
// RL11: In parallel mode the input byte goes into either or both ranks by their enables.
// RL12: The output mux and drive control follow their inputs with no dependence on the shared clock.
`timescale 1ns/1ps
module tpr_store #(
  parameter tpr_pkg::tpr_variant_t VARIANT = tpr_pkg::TPR_REGISTER
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic shared_clk,
  input wire logic rank1_clk_enable_n,
  input wire logic rank2_clk_enable_n,
  input wire logic latch_common_gate,
  input wire logic rank1_gate_n,
  input wire logic rank2_gate_n,
  input wire logic rank2_source_select,
  input wire logic output_rank_select,
  input wire logic output_drive_enable_n,
  input wire logic [tpr_pkg::BYTE_W-1:0] input_byte,
  output logic [tpr_pkg::BYTE_W-1:0] out_bus,
  output logic out_bus_oe
);
  import tpr_pkg::*;

  logic [CTRL_W-1:0] ctrl_pins;
  logic [CTRL_W-1:0] ctrl_s;
  tpr_byte_t data_s;
  logic [CTRL_W-1:0] ctrl_d_reg;
  logic [CTRL_W-1:0] ctrl_d_next;
  tpr_byte_t data_d_reg;
  tpr_byte_t data_d_next;
  logic clk_rise;
  logic load1;
  logic load2;
  tpr_byte_t rank2_src;
  tpr_byte_t out_bus_reg;
  tpr_byte_t out_bus_next;
  logic out_bus_oe_reg;
  logic out_bus_oe_next;

  tpr_rank_if r1 ();
  tpr_rank_if r2 ();

  // A latch rank is open while the common gate is high or its own gate is low.
  function automatic logic rank_open(input logic common_gate, input logic gate_n);
    return common_gate | ~gate_n;
  endfunction

  // Every pin, the shared clock among them, is from outside the core clock domain.
  assign ctrl_pins = {output_drive_enable_n, output_rank_select, rank2_source_select,
                      rank2_gate_n, rank1_gate_n, latch_common_gate,
                      rank2_clk_enable_n, rank1_clk_enable_n, shared_clk};

  tpr_sync #(.W(CTRL_W)) u_sync_ctrl (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(ctrl_pins),
    .sync_out(ctrl_s)
  );

  tpr_sync #(.W(BYTE_W)) u_sync_data (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(input_byte),
    .sync_out(data_s)
  );

  // A one-cycle delayed copy gives the edge detector its reference and
  // supplies the enables and data as they stood before the shared clock rose.
  always_comb
  begin
    ctrl_d_next = ctrl_s;
    data_d_next = data_s;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_d_reg <= CTRL_RST;
      data_d_reg <= BYTE_RST;
    end
    else
    begin
      ctrl_d_reg <= ctrl_d_next;
      data_d_reg <= data_d_next;
    end
  end

  assign clk_rise = ctrl_s[C_CLK] & ~ctrl_d_reg[C_CLK];

  // Load decisions and source selection for both ranks.
  always_comb
  begin
    load1 = 1'b0;
    load2 = 1'b0;
    rank2_src = r1.q;
    r1.din = data_d_reg;
    case (VARIANT)
      TPR_REGISTER:
      begin
        // Enables and data are taken from the cycle before the edge.
        load1 = clk_rise & ~ctrl_d_reg[C_EN1_N]; // RL2
        load2 = clk_rise & ~ctrl_d_reg[C_EN2_N]; // RL3
        r1.din = data_d_reg;
        // Rank 2 sees rank 1's old byte, so one edge shifts the pipe.
        rank2_src = ctrl_d_reg[C_SRC] ? data_d_reg : r1.q; // RL5 RL6 RL11
      end
      TPR_LATCH:
      begin
        // Transparency is a load on every core cycle while open.
        load1 = rank_open(ctrl_s[C_GATE], ctrl_s[C_G1_N]); // RL9 RL10
        load2 = rank_open(ctrl_s[C_GATE], ctrl_s[C_G2_N]); // RL9 RL10
        r1.din = data_s;
        // With both ranks open the byte flows straight through to rank 2.
        if (ctrl_s[C_SRC])
        begin
          rank2_src = data_s; // RL5 RL11
        end
        else if (load1)
        begin
          rank2_src = data_s; // RL5
        end
        else
        begin
          rank2_src = r1.q; // RL5
        end
      end
      default:
      begin
        load1 = 1'b0;
        load2 = 1'b0;
      end
    endcase
    r1.load = load1; // RL1 RL4
    r2.load = load2; // RL1 RL4
    r2.din = rank2_src;
  end

  tpr_rank u_rank1 (
    .core_clk(core_clk),
    .rst(rst),
    .port(r1)
  );

  tpr_rank u_rank2 (
    .core_clk(core_clk),
    .rst(rst),
    .port(r2)
  );

  // The output stage reads the present rank contents and selects, not a
  // shared clock edge; the registered copy costs one core cycle of latency.
  always_comb
  begin
    out_bus_next = ctrl_s[C_OSEL] ? r1.q : r2.q; // RL7 RL12
    out_bus_oe_next = ~ctrl_s[C_OE_N]; // RL8 RL12
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      out_bus_reg <= BYTE_RST;
      out_bus_oe_reg <= 1'b0;
    end
    else
    begin
      out_bus_reg <= out_bus_next;
      out_bus_oe_reg <= out_bus_oe_next;
    end
  end

  assign out_bus = out_bus_reg;
  assign out_bus_oe = out_bus_oe_reg;
endmodule

// ==== tpr_store_checker.sv ====
// Port-level assertions for the two-rank byte store in its register and latch forms.
`timescale 1ns/1ps
module tpr_store_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic shared_clk,
  input wire logic rank1_clk_enable_n,
  input wire logic rank2_clk_enable_n,
  input wire logic latch_common_gate,
  input wire logic rank1_gate_n,
  input wire logic rank2_gate_n,
  input wire logic rank2_source_select,
  input wire logic output_rank_select,
  input wire logic output_drive_enable_n,
  input wire logic [tpr_pkg::BYTE_W-1:0] input_byte,
  input wire logic [tpr_pkg::BYTE_W-1:0] out_bus,
  input wire logic out_bus_oe
);
  import tpr_pkg::*;
  tpr_byte_t m1_reg, m1_next, m2_reg, m2_next;
  logic [16:0] pins, pins_reg;
  logic open1;
  logic open2;
  logic [2:0] cnt_reg, cnt_next;
  logic sc_reg;
  logic quiet;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Reference ranks load at a sampled pin rise; compares wait until the pins sit still.
  always_comb
  begin
    pins = {latch_common_gate, rank1_gate_n, rank2_gate_n, shared_clk, rank1_clk_enable_n,
      rank2_clk_enable_n, rank2_source_select, output_rank_select, output_drive_enable_n,
      input_byte};
    // Latch pins are tied shut on a register instance and the clock idles on a latch one.
    open1 = latch_common_gate || !rank1_gate_n;
    open2 = latch_common_gate || !rank2_gate_n;
    m1_next = m1_reg;
    m2_next = m2_reg;
    if ((shared_clk && !sc_reg && !rank1_clk_enable_n) || open1) m1_next = input_byte;
    if ((shared_clk && !sc_reg && !rank2_clk_enable_n) || open2)
      m2_next = (rank2_source_select || open1) ? input_byte : m1_reg;
    cnt_next = (pins != pins_reg) ? 3'h0 : cnt_reg + {2'h0, cnt_reg != 3'h7};
  end
  // Reset clears the stillness count, so nothing is judged just after release.
  always_ff @(posedge core_clk)
  begin
    m1_reg <= rst ? 8'h00 : m1_next;
    m2_reg <= rst ? 8'h00 : m2_next;
    cnt_reg <= rst ? 3'h0 : cnt_next;
    pins_reg <= pins;
    sc_reg <= shared_clk;
  end
  assign quiet = cnt_reg == 3'h7;
  property p_oe; quiet |-> out_bus_oe == !output_drive_enable_n; endproperty
  a_oe: assert property (p_oe) else $error("Bus drive does not follow enable.");
  property p_rank1; quiet && output_rank_select |-> out_bus == m1_reg; endproperty
  a_rank1: assert property (p_rank1) else $error("Rank 1 byte wrong.");
  property p_par; quiet && !output_rank_select && rank2_source_select |-> out_bus == m2_reg;
  endproperty
  a_par: assert property (p_par) else $error("Parallel rank 2 byte wrong.");
  property p_cas; quiet && !output_rank_select && !rank2_source_select |-> out_bus == m2_reg;
  endproperty
  a_cas: assert property (p_cas) else $error("Cascaded rank 2 byte wrong.");
  property p_hold; quiet |=> $stable(out_bus); endproperty
  a_hold: assert property (p_hold) else $error("Output moved with no cause.");
  property p_off; $rose(output_drive_enable_n) |-> ##[1:4] !out_bus_oe; endproperty
  a_off: assert property (p_off) else $error("Bus not floated in time.");
  property p_on; $fell(output_drive_enable_n) |-> ##[1:4] out_bus_oe; endproperty
  a_on: assert property (p_on) else $error("Bus not driven in time.");
  property p_rst; disable iff (1'b0) rst |=> !out_bus_oe; endproperty
  a_rst: assert property (p_rst) else $error("Bus driven in reset.");
  c_cas: cover property ($rose(shared_clk) && !rank2_clk_enable_n && !rank2_source_select);
  c_par: cover property ($rose(shared_clk) && rank1_clk_enable_n && rank2_source_select);
  c_off: cover property ($rose(output_drive_enable_n));
endmodule
bind tpr_store tpr_store_checker tpr_store_checker_i (.core_clk, .rst, .shared_clk,
  .rank1_clk_enable_n, .rank2_clk_enable_n, .latch_common_gate, .rank1_gate_n, .rank2_gate_n,
  .rank2_source_select, .output_rank_select,
  .output_drive_enable_n, .input_byte, .out_bus, .out_bus_oe);

// ==== tpr_bus_reader.sv ====
// Far-side reader that resolves the three-state output byte.
`timescale 1ns/1ps
module tpr_bus_reader (
  input wire logic core_clk,
  input wire logic [tpr_pkg::BYTE_W-1:0] out_bus,
  input wire logic out_bus_oe,
  output tpr_pkg::tpr_byte_t bus_seen
);
  import tpr_pkg::*;
  tpr_byte_t last_reg, last_next;
  // A floated bus has no keeper, so it shows the inverse of the last driven byte.
  always_comb
  begin
    last_next = out_bus_oe ? out_bus : last_reg;
    bus_seen = out_bus_oe ? out_bus : ~last_reg;
  end
  always_ff @(posedge core_clk)
  begin
    last_reg <= last_next;
  end
endmodule

// ==== tpr_store_tb_top.sv ====
// Self-checking bench for the two-rank byte store in its register and latch forms.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tpr_store_tb_top;
  import tpr_pkg::*;
  logic core_clk = 0, rst = 1, shared_clk = 0, output_drive_enable_n = 0;
  logic rank1_clk_enable_n = 1, rank2_clk_enable_n = 1;
  logic rank2_source_select = 0, output_rank_select = 0, out_bus_oe;
  tpr_byte_t input_byte = 8'h00, out_bus, bus_seen, out_bus_l;
  logic latch_common_gate = 0, rank1_gate_n = 1, rank2_gate_n = 1, out_bus_l_oe;
  int bad_count = 0, n_compared = 0;
  // Rows: enable 1, enable 2, source, output select, data, then the byte expected.
  logic [19:0] rows [6] = '{20'h1a1a1, 20'h0b2a1, 20'hac3c3, 20'h5d4d4, 20'hce5c3, 20'hdf6d4};
  tpr_store tpr_store_i (.core_clk, .rst, .shared_clk, .rank1_clk_enable_n,
    .rank2_clk_enable_n, .latch_common_gate(1'b0), .rank1_gate_n(1'b1), .rank2_gate_n(1'b1),
    .rank2_source_select, .output_rank_select, .output_drive_enable_n, .input_byte,
    .out_bus, .out_bus_oe);
  tpr_bus_reader tpr_bus_reader_i (.core_clk, .out_bus, .out_bus_oe, .bus_seen);
  // Second copy in latch form; its storage clock idles and its clock enables stay off.
  tpr_store #(.VARIANT(TPR_LATCH)) latch_tpr_store_i (.core_clk, .rst, .shared_clk(1'b0),
    .rank1_clk_enable_n(1'b1), .rank2_clk_enable_n(1'b1), .latch_common_gate, .rank1_gate_n,
    .rank2_gate_n, .rank2_source_select, .output_rank_select, .output_drive_enable_n,
    .input_byte, .out_bus(out_bus_l), .out_bus_oe(out_bus_l_oe));
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  // Inputs always move 1 ns after a rising edge, clear of sampling.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic final_report();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #5000;
    bad_count++;
    final_report();
  end
  initial
  begin
    cyc(3);
    rst = 0;
    for (int i = 0; i < 6; i++)
    begin
      {rank1_clk_enable_n, rank2_clk_enable_n, rank2_source_select, output_rank_select,
        input_byte} = rows[i][19:8];
      cyc(3);
      shared_clk = 1'b1;
      cyc(3);
      shared_clk = 1'b0;
      cyc(6);
      `CHK(bus_seen, rows[i][7:0])
    end
    output_rank_select = 1'b0;
    cyc(5);
    `CHK(bus_seen, 8'hc3)
    output_drive_enable_n = 1'b1;
    cyc(5);
    `CHK(out_bus_oe, 1'b0)
    `CHK(bus_seen, 8'h3c)
    output_drive_enable_n = 1'b0;
    rst = 1'b1;
    cyc(2);
    `CHK(out_bus_oe, 1'b0)
    cyc(1);
    rst = 1'b0;
    cyc(6);
    `CHK(bus_seen, 8'h00)
    latch_common_gate = 1'b1;
    input_byte = 8'h5a;
    output_rank_select = 1'b1;
    cyc(6);
    `CHK(out_bus_l, 8'h5a)
    `CHK(out_bus_l_oe, 1'b1)
    latch_common_gate = 1'b0;
    cyc(4);
    input_byte = 8'ha5;
    cyc(6);
    `CHK(out_bus_l, 8'h5a)
    output_rank_select = 1'b0;
    cyc(6);
    `CHK(out_bus_l, 8'h5a)
    rank2_source_select = 1'b1;
    rank2_gate_n = 1'b0;
    cyc(6);
    `CHK(out_bus_l, 8'ha5)
    output_rank_select = 1'b1;
    cyc(6);
    `CHK(out_bus_l, 8'h5a)
    final_report();
  end
endmodule
